//--- uerm_pkg.sv
// Constants for the unit error report mask block
package uerm_pkg;
	localparam logic [11:0] UERM_STATUS_OFS = 12'h140;
	localparam logic [11:0] UERM_MASK_OFS   = 12'h144;
	localparam logic [11:0] UERM_CMD_OFS    = 12'h148;
	localparam logic [11:0] UERM_FIRST_OFS  = 12'h150;
	localparam logic [11:0] UERM_NEXT_OFS   = 12'h154;

	localparam logic [31:0] UERM_MASK_RESET = 32'h0000e000;
	localparam logic [31:0] UERM_IMPL       = 32'h0000ffe7;
	localparam logic [31:0] UERM_ZERO       = 32'h00000000;

	localparam int UERM_NBITS        = 16;
	localparam int UERM_BIT_PQ_OVF   = 15;
	localparam int UERM_BIT_NPQ_OVF  = 14;
	localparam int UERM_BIT_CPL_OVF  = 13;
	localparam int UERM_BIT_LLE      = 12;
	localparam int UERM_BIT_LINK_DN  = 11;
	localparam int UERM_BIT_DQ_PAR   = 10;
	localparam int UERM_BIT_LUT_PAR  = 9;
	localparam int UERM_BIT_RB_DATA  = 8;
	localparam int UERM_BIT_RB_HDR   = 7;
	localparam int UERM_BIT_RB_CTL   = 6;
	localparam int UERM_BIT_FC_TO    = 5;
	localparam int UERM_BIT_CLK_LOW  = 2;
	localparam int UERM_BIT_NAK      = 1;
	localparam int UERM_BIT_ARB      = 0;

	localparam int UERM_CLK_HZ       = 50000000;
	localparam int UERM_CLK_LOW_MS   = 25;
	localparam int UERM_CLK_LOW_CYC  = UERM_CLK_HZ / 1000 * UERM_CLK_LOW_MS;
	localparam int UERM_CNT_W        = 21;
endpackage : uerm_pkg

//--- uerm_top.sv
// Unit error report mask, status and error logs behind an APB slave
`timescale 1ns/1ps
module uerm_top
	import uerm_pkg::*;
#(
	parameter int CLK_LOW_CYCLES = UERM_CLK_LOW_CYC
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic                   por_n,
	input  wire logic [11:0]            paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [UERM_NBITS-1:0]  err_event,
	input  wire logic                   link_up,
	input  wire logic                   sec_bus_reset,
	input  wire logic                   link_disable,
	input  wire logic                   loopback_en,
	input  wire logic                   mgmt_clk_pin,
	output logic      [UERM_NBITS-1:0]  err_report,
	output logic      [UERM_NBITS-1:0]  global_first_error_log,
	output logic      [UERM_NBITS-1:0]  global_next_error_log
);

	// Elaboration checks
	initial begin
		if (CLK_LOW_CYCLES < 1 || CLK_LOW_CYCLES >= (1 << UERM_CNT_W)) begin
			$error("CLK_LOW_CYCLES out of range");
		end
		if (UERM_NBITS != 16) begin
			$error("Status width must be 16 bits");
		end
		if ((UERM_MASK_RESET & ~UERM_IMPL) != UERM_ZERO) begin
			$error("Mask reset value touches reserved bits");
		end
		if (UERM_BIT_PQ_OVF >= UERM_NBITS || UERM_BIT_ARB < 0) begin
			$error("Error bit positions outside the status width");
		end
	end

	localparam logic [UERM_CNT_W-1:0] LOW_LIMIT = UERM_CNT_W'(CLK_LOW_CYCLES);

	// Register storage
	logic [31:0]            unit_error_report_mask;
	logic [UERM_NBITS-1:0]  unit_error_status;
	logic [UERM_NBITS-1:0]  local_first_error_log;
	logic [UERM_NBITS-1:0]  local_next_error_log;

	// Event path
	logic [UERM_NBITS-1:0]  evt;
	logic [UERM_NBITS-1:0]  unmasked;
	logic                   link_up_d;
	logic                   link_down_evt;
	logic                   mclk_s1;
	logic                   mclk_s2;
	logic [UERM_CNT_W-1:0]  low_cnt;
	logic                   clk_low_evt;

	// Bus path
	logic                   wr_go;
	logic [31:0]            byte_mask;
	logic [31:0]            status_clr;
	logic [31:0]            first_clr;
	logic [31:0]            next_clr;
	logic                   first_empty;
	logic                   setup_ph;
	logic                   mask_wr;
	logic                   status_wr;
	logic                   first_wr;
	logic                   next_wr;

	function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
		reg_hit = (a[11:2] == ofs[11:2]);
	endfunction : reg_hit

	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		logic [31:0] m;
		m = UERM_ZERO;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		lane_mask = m;
	endfunction : lane_mask

	function automatic logic mapped(input logic [11:0] a);
		mapped = reg_hit(a, UERM_STATUS_OFS) || reg_hit(a, UERM_MASK_OFS) ||
			reg_hit(a, UERM_CMD_OFS) || reg_hit(a, UERM_FIRST_OFS) ||
			reg_hit(a, UERM_NEXT_OFS);
	endfunction : mapped

	// Write takes effect at the sampling edge of the access phase
	assign wr_go     = psel && penable && pready && pwrite;
	assign byte_mask = lane_mask(pstrb);

	// Setup phase of an APB transfer
	assign setup_ph  = psel && !penable;

	// Per-register write strobes
	assign mask_wr   = wr_go && reg_hit(paddr, UERM_MASK_OFS);
	assign status_wr = wr_go && reg_hit(paddr, UERM_STATUS_OFS);
	assign first_wr  = wr_go && reg_hit(paddr, UERM_FIRST_OFS);
	assign next_wr   = wr_go && reg_hit(paddr, UERM_NEXT_OFS);

	assign status_clr = status_wr ? (pwdata & byte_mask & UERM_IMPL) : UERM_ZERO;
	assign first_clr  = first_wr ? (pwdata & byte_mask & UERM_IMPL) : UERM_ZERO;
	assign next_clr   = next_wr ? (pwdata & byte_mask & UERM_IMPL) : UERM_ZERO;

	// Link-down transition detect
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			link_up_d <= 1'b0;
		end else begin
			link_up_d <= link_up;
		end
	end

	assign link_down_evt = link_up_d && !link_up &&
		!(sec_bus_reset || link_disable || loopback_en);

	// Management bus clock synchroniser
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mclk_s1 <= 1'b1;
			mclk_s2 <= 1'b1;
		end else begin
			mclk_s1 <= mgmt_clk_pin;
			mclk_s2 <= mclk_s1;
		end
	end

	// Clock-low duration counter, saturating
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			low_cnt <= '0;
		end else if (mclk_s2) begin
			low_cnt <= '0;
		end else if (low_cnt != LOW_LIMIT) begin
			low_cnt <= low_cnt + 1'b1;
		end
	end

	assign clk_low_evt = !mclk_s2 && (low_cnt == LOW_LIMIT - 1'b1);

	// Event assembly
	always_comb begin
		evt = err_event & UERM_IMPL[UERM_NBITS-1:0];
		evt[UERM_BIT_LINK_DN] = link_down_evt;
		evt[UERM_BIT_CLK_LOW] = clk_low_evt;
	end

	// Mask gates the report and both local logs, not the status
	assign unmasked = evt & ~unit_error_report_mask[UERM_NBITS-1:0];
	// Bits 15 to 5 and 2 to 0 gate in place

	assign first_empty = (local_first_error_log == '0);

	// Mask register, reset only on power-on
	always_ff @(posedge sys_clk) begin
		if (!por_n) begin
			unit_error_report_mask <= UERM_MASK_RESET;
		end else if (mask_wr) begin
			unit_error_report_mask <= (unit_error_report_mask & ~byte_mask) |
				(pwdata & byte_mask & UERM_IMPL);
		end
	end

	// Per-bit status and log cells
	genvar g;
	generate
		for (g = 0; g < UERM_NBITS; g++) begin : g_cell
			always_ff @(posedge sys_clk) begin
				if (!por_n) begin
					unit_error_status[g] <= 1'b0;
				end else if (evt[g]) begin
					unit_error_status[g] <= 1'b1;
				end else if (status_clr[g]) begin
					unit_error_status[g] <= 1'b0;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!por_n) begin
					local_first_error_log[g] <= 1'b0;
				end else if (unmasked[g] && first_empty) begin
					local_first_error_log[g] <= 1'b1;
				end else if (first_clr[g]) begin
					local_first_error_log[g] <= 1'b0;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!por_n) begin
					local_next_error_log[g] <= 1'b0;
				end else if (unmasked[g] && !first_empty) begin
					local_next_error_log[g] <= 1'b1;
				end else if (next_clr[g]) begin
					local_next_error_log[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Report towards the global error logs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			err_report <= '0;
		end else begin
			err_report <= unmasked;
		end
	end

	// Global first log, loads while empty
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			global_first_error_log <= '0;
		end else if (global_first_error_log == '0) begin
			global_first_error_log <= err_report;
		end
	end

	// Global next log, gathers once first is taken
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			global_next_error_log <= '0;
		end else if (global_first_error_log != '0) begin
			global_next_error_log <= global_next_error_log | err_report;
		end
	end

	// APB answer, one access cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_ph;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			pslverr <= !mapped(paddr);
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Read decode, command and unmapped words read zero
	function automatic logic [31:0] read_word(input logic [11:0] a);
		logic [31:0] w;
		w = UERM_ZERO;
		if (reg_hit(a, UERM_MASK_OFS)) begin
			w = unit_error_report_mask & UERM_IMPL;
		end else if (reg_hit(a, UERM_STATUS_OFS)) begin
			w = {16'h0000, unit_error_status};
		end else if (reg_hit(a, UERM_FIRST_OFS)) begin
			w = {16'h0000, local_first_error_log};
		end else if (reg_hit(a, UERM_NEXT_OFS)) begin
			w = {16'h0000, local_next_error_log};
		end
		read_word = w;
	endfunction : read_word

	// Read data captured in the setup cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata <= UERM_ZERO;
		end else if (setup_ph && !pwrite) begin
			prdata <= read_word(paddr);
		end else begin
			prdata <= UERM_ZERO;
		end
	end

endmodule : uerm_top

//--- uerm_top_assertions.sv
// Concurrent checks on the ports of the unit error report mask block
`timescale 1ns/1ps
module uerm_checker
	import uerm_pkg::*;
(
	input logic                  sys_clk,
	input logic                  rst_n,
	input logic [11:0]           paddr,
	input logic                  psel,
	input logic                  penable,
	input logic [31:0]           prdata,
	input logic                  pready,
	input logic                  pslverr,
	input logic [UERM_NBITS-1:0] err_event,
	input logic [UERM_NBITS-1:0] err_report,
	input logic [UERM_NBITS-1:0] global_first_error_log
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	logic mapped;
	assign mapped = paddr inside {12'h140, 12'h144, 12'h148, 12'h150, 12'h154};
	chk_ready_next: assert property (s_setup |=> s_access)
		else $error("no ready after setup");
	chk_ready_only: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	chk_unmapped_err: assert property (pready |-> pslverr == !mapped)
		else $error("wrong slave error");
	chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("bus outputs not idle");
	chk_report_cause: assert property (|(err_report & 16'hf7e3 & ~$past(err_event)) == 0)
		else $error("report without event");
	chk_no_reserved: assert property (err_report[4:3] == 2'b00)
		else $error("reserved report bit");
	chk_first_load: assert property (global_first_error_log == 0 && err_report != 0
		|=> global_first_error_log == $past(err_report))
		else $error("first log not loaded");
	chk_first_hold: assert property (global_first_error_log != 0
		|=> $stable(global_first_error_log))
		else $error("first log changed");
endmodule : uerm_checker

bind uerm_top uerm_checker u_chk (.sys_clk, .rst_n, .paddr, .psel, .penable, .prdata,
	.pready, .pslverr, .err_event, .err_report, .global_first_error_log);

//--- tb_unit_error_report_mask.sv
// Self-checking bench for the unit error report mask block
`timescale 1ns/1ps
module tb_unit_error_report_mask
	import uerm_pkg::*;
;
	logic        sys_clk = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic        link_up = 1, sec_bus_reset = 0, link_disable = 0, loopback_en = 0;
	logic        mgmt_clk_pin = 1, pready, pslverr, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic [15:0] err_event = 16'h0, err_report, gfirst, gnext;
	int          n_mismatch = 0, num_checks = 0, mdl_mask, b;
	int          q[$] = {15, 14, 13, 12, 10, 9, 8, 7, 6, 5, 1, 0};
	always #10 sys_clk = ~sys_clk;
	uerm_top #(.CLK_LOW_CYCLES(20)) u_dut (.sys_clk, .rst_n, .por_n, .paddr, .psel, .penable,
		.pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .err_event, .link_up,
		.sec_bus_reset, .link_disable, .loopback_en, .mgmt_clk_pin, .err_report,
		.global_first_error_log(gfirst), .global_next_error_log(gnext));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rst(input logic p);
		@(posedge sys_clk);
		rst_n <= 0;
		por_n <= p;
		@(posedge sys_clk);
		rst_n <= 1;
		por_n <= 1;
	endtask : rst
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	initial begin
		#100us;
		n_mismatch++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h7c67));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1;
		por_n <= 1;
		apb(0, UERM_MASK_OFS, 0);
		chk(rd, 32'h0000e000);
		apb(0, 12'h15c, 0);
		chk(er, 1);
		apb(1, UERM_MASK_OFS, 32'hffffffff);
		apb(0, UERM_MASK_OFS, 0);
		chk(rd, 32'h0000ffe7);
		mdl_mask = $urandom & 32'hffe7;
		apb(1, UERM_MASK_OFS, mdl_mask);
		rst(1);
		apb(0, UERM_MASK_OFS, 0);
		chk(rd, mdl_mask);
		rst(0);
		apb(0, UERM_MASK_OFS, 0);
		chk(rd, 32'h0000e000);
		$display("register test done");
		foreach (q[i]) begin
			b = q[i];
			mdl_mask = $urandom & 32'hffe7;
			apb(1, UERM_MASK_OFS, mdl_mask);
			@(posedge sys_clk);
			err_event <= 16'(1 << b);
			@(posedge sys_clk);
			err_event <= 16'h0;
			@(posedge sys_clk);
			chk(err_report, mdl_mask[b] ? 0 : 1 << b);
			@(posedge sys_clk);
			chk(gfirst, mdl_mask[b] ? 0 : 1 << b);
			apb(0, UERM_STATUS_OFS, 0);
			chk(rd, 1 << b);
			apb(0, UERM_FIRST_OFS, 0);
			chk(rd, mdl_mask[b] ? 0 : 1 << b);
			apb(1, UERM_STATUS_OFS, 32'hffff);
			apb(1, UERM_FIRST_OFS, 32'hffff);
			apb(0, UERM_STATUS_OFS, 0);
			chk(rd, 0);
			rst(1);
		end
		$display("event test done");
		apb(1, UERM_MASK_OFS, 0);
		for (int i = 0; i < 4; i++) begin
			{sec_bus_reset, link_disable, loopback_en} <= 3'(8 >> i);
			@(posedge sys_clk);
			link_up <= 0;
			repeat (2) @(posedge sys_clk);
			chk(err_report[11], i == 0);
			link_up <= 1;
		end
		@(posedge sys_clk);
		{sec_bus_reset, link_disable, loopback_en} <= 3'b000;
		$display("link test done");
		rst(1);
		@(posedge sys_clk);
		err_event <= 16'h0400;
		@(posedge sys_clk);
		err_event <= 16'h0200;
		@(posedge sys_clk);
		err_event <= 16'h0000;
		repeat (2) @(posedge sys_clk);
		chk(gfirst, 32'h0400);
		chk(gnext, 32'h0200);
		apb(0, UERM_NEXT_OFS, 0);
		chk(rd, 32'h0600);
		$display("next log test done");
		b = 0;
		mgmt_clk_pin <= 0;
		repeat (40) begin
			@(posedge sys_clk);
			b += err_report[2];
		end
		chk(b, 1);
		mgmt_clk_pin <= 1;
		$display("clock low test done");
		complete_run();
	end
endmodule : tb_unit_error_report_mask
